// ### design/rs_stripe_controller.sv
// Purpose: Two-channel stripe controller, 512-byte stripes alternating per channel
// Assumes: Channel controllers and all FIFOs share SYS_CLK_IN; counts in 512-bit words
// Notes:   A 4-beat buffer sits between the read pipeline and the destination FIFO
//
// Contract
// - Reset is synchronous and active low, released once the clock is stable.
// - Command codes: identify, shutdown, write, read, SMART, flush; others reserved.
// - Start address is 48 bits in 512-byte blocks across both drives.
// - Request only while idle, held until busy rises, then dropped.
// - Busy stays high during a command; no new request meanwhile.
// - Capacity resets to zero, after identify equals first drive capacity times two.
// - Sector mode defaults zero, set after identify; 4 KB mode unsupported.
// - Two error vectors copied from channels; sticky flag set when any nonzero.
// - Host receive count detects full and pauses read output.
// - Host transmit count gates write input; empty flag ignored.
// - Write check: finish at zero length, else need stripe stored and room.
// - Transfer lasts eight cycles per stripe, one pop each cycle.
// - Data steered by the channel select delayed two clocks.
// - Channel advances per stripe; lookahead selects the count, one clock late.
// - After write stripe: two stripes stored go check, else settle three cycles.
// - Read check: length left, channel stripe stored, host room for two.
// - Read transfer pops the active channel receive FIFO eight cycles.
// - After read stripe continue while length left, else wait channels idle.
// - First channel comes from the start address least significant bit.

module rs_beat_fifo import rs_pkg::*; #(
   parameter int W     = 513,
   parameter int DEPTH = 4
) (
   input  wire logic                       clk_in,
   input  wire logic                       rst_n_in,
   input  wire logic                       ce_in,
   input  wire logic                       in_valid_in,
   output logic                            in_ready_out,
   input  wire logic [W-1:0]               in_data_in,
   output logic                            out_valid_out,
   input  wire logic                       out_ready_in,
   output logic [W-1:0]                    out_data_out,
   output logic [$clog2(DEPTH+1)-1:0]      level_out
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] LVL_FULL = (PW+1)'(DEPTH);
   logic [W-1:0]  mem_ff [DEPTH];
   logic [PW-1:0] wr_ff;
   logic [PW-1:0] rd_ff;
   logic [PW:0]   lvl_ff;
   logic          push;
   logic          pull;

   assign in_ready_out  = (lvl_ff != LVL_FULL);
   assign out_valid_out = (lvl_ff != '0);
   assign out_data_out  = mem_ff[rd_ff];
   assign level_out     = lvl_ff;
   assign push          = ce_in & in_valid_in & in_ready_out;
   assign pull          = ce_in & out_valid_out & out_ready_in;

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         lvl_ff <= '0;
      end else begin
         if (push) begin
            wr_ff <= wr_ff + 1'b1;
         end
         if (pull) begin
            rd_ff <= rd_ff + 1'b1;
         end
         lvl_ff <= lvl_ff + (PW+1)'(push) - (PW+1)'(pull);
      end
   end
endmodule : rs_beat_fifo

module rs_stripe_controller import rs_pkg::*; (
   // Clock, reset, freeze
   input  wire logic                 SYS_CLK_IN,
   input  wire logic                 RST_N_IN,
   input  wire logic                 CE_IN,
   // Host command
   input  wire logic                 COMMAND_REQUEST_IN,
   input  wire logic [2:0]           COMMAND_CODE_IN,
   input  wire logic [AW-1:0]        START_BLOCK_INDEX_IN,
   input  wire logic [AW-1:0]        TRANSFER_BLOCK_COUNT_IN,
   output logic                      ARRAY_BUSY_OUT,
   // Host status
   output logic [AW-1:0]             ARRAY_CAPACITY_OUT,
   output logic                      SECTOR_SIZE_MODE_OUT,
   output logic                      ARRAY_ERROR_FLAG_OUT,
   output logic [1:0][31:0]          CHANNEL_ERROR_VECTOR_OUT,
   // Host receive FIFO
   input  wire logic [CW-1:0]        HOST_RX_FIFO_COUNT_IN,
   output logic                      HOST_RX_FIFO_PUSH_OUT,
   output logic [DW-1:0]             HOST_RX_FIFO_WORD_OUT,
   // Host transmit FIFO
   input  wire logic [CW-1:0]        HOST_TX_FIFO_COUNT_IN,
   input  wire logic                 HOST_TX_FIFO_EMPTY_UNUSED_IN,
   output logic                      HOST_TX_FIFO_POP_OUT,
   input  wire logic [DW-1:0]        HOST_TX_FIFO_WORD_IN,
   // Channel controllers
   output logic [1:0]                CHAN_REQUEST_OUT,
   output rs_cmd_t [1:0]             CHAN_CMD_OUT,
   input  wire logic [1:0]           CHAN_BUSY_IN,
   input  wire logic [1:0][31:0]     CHAN_ERROR_VECTOR_IN,
   input  wire logic [AW-1:0]        CHAN0_CAPACITY_IN,
   input  wire logic                 CHAN0_SECTOR_MODE_IN,
   // Channel transmit FIFOs
   input  wire logic [1:0][CW-1:0]   CHAN_TX_FIFO_FILL_IN,
   output logic [1:0]                CHAN_TX_FIFO_PUSH_OUT,
   output logic [DW-1:0]             CHAN_TX_FIFO_WORD_OUT,
   // Channel receive FIFOs
   input  wire logic [1:0][CW-1:0]   CHAN_RX_FIFO_FILL_IN,
   output logic [1:0]                CHAN_RX_FIFO_POP_OUT,
   input  wire logic [1:0][DW-1:0]   CHAN_RX_FIFO_WORD_IN
);
   localparam int BW = $bits(rs_beat_t);

   function automatic rs_cmd_t chan_share(input logic [2:0] code, input logic [AW-1:0] a,
                                          input logic [AW-1:0] n, input logic c);
      logic [AW:0] first;
      logic [AW:0] last;
      first = {1'b0, a} + {{AW{1'b0}}, ~c};
      last  = {1'b0, a} + {1'b0, n} + {{AW{1'b0}}, ~c};
      chan_share.code = code;
      chan_share.addr = first[AW:1];
      chan_share.len  = last[AW:1] - first[AW:1];
   endfunction : chan_share

   function automatic logic has_room(input logic [CW-1:0] cnt, input logic [CW-1:0] depth);
      has_room = (cnt <= depth) && ((depth - cnt) >= TWO_STRIPES);
   endfunction : has_room

   rs_state_t       state_ff;
   rs_cmd_t [1:0]   chan_cmd_ff;
   logic [1:0]      chan_req_ff;
   logic [2:0]      code_ff;
   logic            is_read_ff;
   logic [AW-1:0]   remain_ff;
   logic [2:0]      beat_cnt_ff;
   logic [1:0]      settle_ff;
   logic [2:0]      active_channel_pipe_ff;
   logic            lookahead_channel_ff;
   logic [CW-1:0]   chan_tx_sel_ff;
   logic [CW-1:0]   chan_rx_sel_ff;
   logic            busy_ff;
   logic            p1_ff;
   logic            p2_ff;
   logic [DW-1:0]   stage_word_ff;
   logic [AW-1:0]   capacity_ff;
   logic            mode_ff;
   logic [1:0][31:0] err_vec_ff;
   logic            err_flag_ff;
   logic [DW-1:0]   out_word_ff;
   logic [1:0]      tx_push_ff;
   logic            rx_push_ff;

   logic            take;
   logic            is_xfer;
   logic            go;
   logic            pop;
   logic            stripe_end;
   logic            drained;
   logic            buf_in_ready;
   logic            buf_out_valid;
   logic            buf_out_ready;
   rs_beat_t        buf_out;
   rs_beat_t        buf_in;
   logic [2:0]      buf_level;
   logic [3:0]      in_flight;
   rs_cmd_t [1:0]   chan_split;

   // Per-channel share of the incoming command
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         chan_split[c] = chan_share(COMMAND_CODE_IN, START_BLOCK_INDEX_IN,
                                    TRANSFER_BLOCK_COUNT_IN, c[0]);
      end
   end

   assign is_xfer = (COMMAND_CODE_IN == CMD_WRITE) || (COMMAND_CODE_IN == CMD_READ);
   assign take    = CE_IN & COMMAND_REQUEST_IN & ~busy_ff & (state_ff == STATE_IDLE);
   // Empty flag deliberately ignored; only the count gates writes
   assign go = is_read_ff
             ? (chan_rx_sel_ff >= STRIPE_WORDS) && has_room(HOST_RX_FIFO_COUNT_IN, HOST_FIFO_WORDS)
             : (HOST_TX_FIFO_COUNT_IN >= STRIPE_WORDS) && has_room(chan_tx_sel_ff, CHAN_FIFO_WORDS);
   // Credit check so words already in the pipeline always find a slot
   assign in_flight  = 4'(buf_level) + 4'(p1_ff) + 4'(p2_ff);
   assign pop        = CE_IN & (state_ff == STATE_MOVE_STRIPE) & (in_flight < 4'(BUF_DEPTH));
   assign stripe_end = pop & (beat_cnt_ff == STRIPE_LAST);
   assign drained    = (chan_req_ff == '0) & (CHAN_BUSY_IN == '0) & ~p1_ff & ~p2_ff
                     & ~buf_out_valid;

   assign HOST_TX_FIFO_POP_OUT    = pop & ~is_read_ff;
   assign CHAN_RX_FIFO_POP_OUT[0] = pop & is_read_ff & ~active_channel_pipe_ff[0];
   assign CHAN_RX_FIFO_POP_OUT[1] = pop & is_read_ff & active_channel_pipe_ff[0];

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         state_ff    <= STATE_IDLE;
         beat_cnt_ff <= '0;
         settle_ff   <= '0;
      end else if (CE_IN) begin
         unique case (state_ff)
            STATE_IDLE: begin
               if (take) begin
                  state_ff  <= is_xfer ? STATE_SETTLE_COUNTS : STATE_DRAIN_CHANNELS;
                  settle_ff <= '0;
               end
            end
            STATE_ISSUE: begin
               state_ff <= STATE_SETTLE_COUNTS;
            end
            STATE_SETTLE_COUNTS: begin
               settle_ff <= settle_ff + 1'b1;
               if (settle_ff == SETTLE_LAST) begin
                  state_ff <= STATE_CHECK_READY;
               end
            end
            STATE_CHECK_READY: begin
               beat_cnt_ff <= '0;
               if (remain_ff == '0) begin
                  state_ff <= STATE_DRAIN_CHANNELS;
               end else if (go) begin
                  state_ff <= STATE_MOVE_STRIPE;
               end
            end
            STATE_MOVE_STRIPE: begin
               if (pop) begin
                  beat_cnt_ff <= beat_cnt_ff + 1'b1;
               end
               if (stripe_end && is_read_ff) begin
                  state_ff <= (remain_ff != ONE_BLOCK) ? STATE_MOVE_STRIPE
                                                       : STATE_DRAIN_CHANNELS;
               end else if (stripe_end) begin
                  settle_ff <= '0;
                  state_ff  <= (HOST_TX_FIFO_COUNT_IN >= TWO_STRIPES) ? STATE_CHECK_READY
                                                                      : STATE_SETTLE_COUNTS;
               end
            end
            STATE_DRAIN_CHANNELS: begin
               if (drained) begin
                  state_ff <= STATE_IDLE;
               end
            end
         endcase
      end
   end

   // Command capture and per-channel split
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         busy_ff     <= 1'b0;
         code_ff     <= CMD_IDENTIFY;
         is_read_ff  <= 1'b0;
         remain_ff   <= '0;
         chan_cmd_ff <= '0;
         chan_req_ff <= '0;
      end else if (CE_IN) begin
         if (take) begin
            busy_ff    <= 1'b1;
            code_ff    <= COMMAND_CODE_IN;
            is_read_ff <= (COMMAND_CODE_IN == CMD_READ);
            remain_ff  <= is_xfer ? TRANSFER_BLOCK_COUNT_IN : '0;
            for (int c = 0; c < 2; c++) begin
               chan_cmd_ff[c] <= chan_split[c];
               chan_req_ff[c] <= ~is_xfer || (chan_split[c].len != '0);
            end
         end else begin
            for (int c = 0; c < 2; c++) begin
               if (CHAN_BUSY_IN[c]) begin
                  chan_req_ff[c] <= 1'b0;
               end
            end
            if (stripe_end) begin
               remain_ff <= remain_ff - ONE_BLOCK;
            end
            if (state_ff == STATE_DRAIN_CHANNELS && drained) begin
               busy_ff <= 1'b0;
            end
         end
      end
   end

   // Channel select, lookahead and count multiplexers
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         active_channel_pipe_ff <= '0;
         lookahead_channel_ff   <= 1'b0;
         chan_tx_sel_ff         <= '0;
         chan_rx_sel_ff         <= '0;
      end else if (CE_IN) begin
         active_channel_pipe_ff[2:1] <= active_channel_pipe_ff[1:0];
         if (take) begin
            active_channel_pipe_ff[0] <= START_BLOCK_INDEX_IN[0];
            lookahead_channel_ff      <= START_BLOCK_INDEX_IN[0];
         end else begin
            if (stripe_end) begin
               active_channel_pipe_ff[0] <= ~active_channel_pipe_ff[0];
            end
            if (state_ff == STATE_MOVE_STRIPE) begin
               lookahead_channel_ff <= ~active_channel_pipe_ff[0];
            end
         end
         chan_tx_sel_ff <= CHAN_TX_FIFO_FILL_IN[lookahead_channel_ff];
         chan_rx_sel_ff <= CHAN_RX_FIFO_FILL_IN[lookahead_channel_ff];
      end
   end

   // Read-latency pipeline into the beat buffer
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         p1_ff         <= 1'b0;
         p2_ff         <= 1'b0;
         stage_word_ff <= '0;
      end else if (CE_IN) begin
         p1_ff <= pop;
         p2_ff <= p1_ff;
         if (p1_ff) begin
            stage_word_ff <= is_read_ff ? CHAN_RX_FIFO_WORD_IN[active_channel_pipe_ff[1]]
                                        : HOST_TX_FIFO_WORD_IN;
         end
      end
   end

   assign buf_in.ch   = active_channel_pipe_ff[2];
   assign buf_in.word = stage_word_ff;
   // Full destination stalls the buffer drain, credit then stalls pops
   assign buf_out_ready = is_read_ff ? (HOST_RX_FIFO_COUNT_IN < HOST_FIFO_WORDS)
                                     : (CHAN_TX_FIFO_FILL_IN[buf_out.ch] < CHAN_FIFO_WORDS);

   rs_beat_fifo #(
      .W     (BW),
      .DEPTH (BUF_DEPTH)
   ) i_rs_beat_fifo (
      .clk_in        (SYS_CLK_IN),
      .rst_n_in      (RST_N_IN),
      .ce_in         (CE_IN),
      .in_valid_in   (p2_ff),
      .in_ready_out  (buf_in_ready),
      .in_data_in    (buf_in),
      .out_valid_out (buf_out_valid),
      .out_ready_in  (buf_out_ready),
      .out_data_out  (buf_out),
      .level_out     (buf_level)
   );

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         out_word_ff <= '0;
         tx_push_ff  <= '0;
         rx_push_ff  <= 1'b0;
      end else if (CE_IN) begin
         tx_push_ff <= '0;
         rx_push_ff <= 1'b0;
         if (buf_out_valid && buf_out_ready) begin
            out_word_ff <= buf_out.word;
            if (is_read_ff) begin
               rx_push_ff <= 1'b1;
            end else begin
               tx_push_ff[buf_out.ch] <= 1'b1;
            end
         end
      end
   end

   // Identify results and error collection
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         capacity_ff <= '0;
         mode_ff     <= 1'b0;
         err_vec_ff  <= '0;
         err_flag_ff <= 1'b0;
      end else if (CE_IN) begin
         if (state_ff == STATE_DRAIN_CHANNELS && drained && code_ff == CMD_IDENTIFY) begin
            capacity_ff <= {CHAN0_CAPACITY_IN[AW-2:0], 1'b0};
            mode_ff     <= CHAN0_SECTOR_MODE_IN;
         end
         err_vec_ff <= CHAN_ERROR_VECTOR_IN;
         if (err_vec_ff != '0) begin
            err_flag_ff <= 1'b1;
         end
      end
   end

   assign ARRAY_BUSY_OUT           = busy_ff;
   assign ARRAY_CAPACITY_OUT       = capacity_ff;
   assign SECTOR_SIZE_MODE_OUT     = mode_ff;
   assign ARRAY_ERROR_FLAG_OUT     = err_flag_ff;
   assign CHANNEL_ERROR_VECTOR_OUT = err_vec_ff;
   assign HOST_RX_FIFO_PUSH_OUT    = rx_push_ff;
   assign HOST_RX_FIFO_WORD_OUT    = out_word_ff;
   assign CHAN_TX_FIFO_PUSH_OUT    = tx_push_ff;
   assign CHAN_TX_FIFO_WORD_OUT    = out_word_ff;
   assign CHAN_REQUEST_OUT         = chan_req_ff;
   assign CHAN_CMD_OUT             = chan_cmd_ff;

   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_N_IN || !CE_IN);

   sequence s_settle3;
      (state_ff == STATE_SETTLE_COUNTS) [*3] ##1 (state_ff == STATE_CHECK_READY);
   endsequence

   busy_take_a: assert property (take |=> busy_ff && state_ff != STATE_IDLE)
      else $error("busy did not rise after request");
   busy_end_a: assert property ($fell(busy_ff) |-> $past(state_ff) == STATE_DRAIN_CHANNELS)
      else $error("busy fell outside drain");
   settle_len_a: assert property ($rose(state_ff == STATE_SETTLE_COUNTS) |-> s_settle3)
      else $error("settle did not last three cycles");
   stripe_dec_a: assert property (stripe_end |=> remain_ff == $past(remain_ff) - ONE_BLOCK)
      else $error("length not decremented per stripe");
   beat_chan_a: assert property (p2_ff |-> buf_in.ch == $past(active_channel_pipe_ff[0], 2))
      else $error("beat steered to wrong channel");
   pop_move_a: assert property ((CHAN_RX_FIFO_POP_OUT != '0 || HOST_TX_FIFO_POP_OUT)
                                |-> state_ff == STATE_MOVE_STRIPE)
      else $error("pop outside transfer state");
   check_done_a: assert property (state_ff == STATE_CHECK_READY && remain_ff == '0
                                  |=> state_ff == STATE_DRAIN_CHANNELS)
      else $error("zero length did not finish");
   check_go_a: assert property (state_ff == STATE_CHECK_READY && remain_ff != '0 && go
                                |=> state_ff == STATE_MOVE_STRIPE)
      else $error("ready stripe not started");
   first_chan_a: assert property (take |=> active_channel_pipe_ff[0]
                                  == $past(START_BLOCK_INDEX_IN[0]))
      else $error("wrong first channel");
   err_sticky_a: assert property (err_flag_ff |=> err_flag_ff)
      else $error("error flag cleared without reset");
   buf_room_a: assert property (p2_ff |-> buf_in_ready)
      else $error("beat buffer overflow");
endmodule : rs_stripe_controller

// ### design/rs_pkg.sv
// Purpose: Shared constants and types for the two-channel stripe controller
// Assumes: All FIFO counts are in 512-bit words, 8 words per 512-byte stripe
// Notes:   Command codes, thresholds and state codes live here only
package rs_pkg;
   localparam int DW        = 512;
   localparam int AW        = 48;
   localparam int CW        = 16;
   localparam int BUF_DEPTH = 4;

   localparam logic [2:0] CMD_IDENTIFY = 3'h0;
   localparam logic [2:0] CMD_SHUTDOWN = 3'h1;
   localparam logic [2:0] CMD_WRITE    = 3'h2;
   localparam logic [2:0] CMD_READ     = 3'h3;
   localparam logic [2:0] CMD_SMART    = 3'h4;
   localparam logic [2:0] CMD_FLUSH    = 3'h6;

   localparam logic [CW-1:0] STRIPE_WORDS    = 16'h0008;
   localparam logic [CW-1:0] TWO_STRIPES     = 16'h0010;
   localparam logic [CW-1:0] HOST_FIFO_WORDS = 16'h0200;
   localparam logic [CW-1:0] CHAN_FIFO_WORDS = 16'h0200;
   localparam logic [2:0]    STRIPE_LAST     = 3'h7;
   localparam logic [1:0]    SETTLE_LAST     = 2'h2;
   localparam logic [AW-1:0] ONE_BLOCK       = 48'h0000_0000_0001;

   typedef struct packed {
      logic          ch;
      logic [DW-1:0] word;
   } rs_beat_t;

   typedef struct packed {
      logic [2:0]    code;
      logic [AW-1:0] addr;
      logic [AW-1:0] len;
   } rs_cmd_t;

   typedef enum logic [5:0] {
      STATE_IDLE           = 6'b000001,
      STATE_ISSUE          = 6'b000010,
      STATE_SETTLE_COUNTS  = 6'b000100,
      STATE_CHECK_READY    = 6'b001000,
      STATE_MOVE_STRIPE    = 6'b010000,
      STATE_DRAIN_CHANNELS = 6'b100000
   } rs_state_t;
endpackage : rs_pkg

// ### tb/rs_far_model.sv
// Purpose: Far side model, host transmit FIFO data and channel controllers
// Assumes: Channel busy lasts six cycles per request
// Notes:   Idle data lines show the inverse of their last value
module rs_far_model import rs_pkg::*; (
   // Clock and reset
   input  wire logic               clk_in,
   input  wire logic               rst_n_in,
   // Host transmit FIFO
   input  wire logic               host_pop_in,
   output logic [DW-1:0]           host_word_out,
   // Channel controllers
   input  wire logic [1:0]         chan_req_in,
   output logic [1:0]              chan_busy_out,
   input  wire logic [1:0]         chan_pop_in,
   output logic [1:0][DW-1:0]      chan_word_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0]      host_seq_ff;
   logic [1:0][15:0] chan_seq_ff;
   logic [1:0][2:0]  busy_cnt_ff;
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         host_seq_ff <= 16'h0;
         chan_seq_ff <= '0;
         busy_cnt_ff <= '0;
      end else begin
         host_seq_ff <= host_seq_ff + 16'(host_pop_in);
         for (int c = 0; c < 2; c++) begin
            chan_seq_ff[c] <= chan_seq_ff[c] + 16'(chan_pop_in[c]);
            if (busy_cnt_ff[c] != 3'h0)
               busy_cnt_ff[c] <= busy_cnt_ff[c] - 3'h1;
            else if (chan_req_in[c])
               busy_cnt_ff[c] <= 3'h6;
         end
      end
   end
   // Words one cycle after the pop
   always_ff @(posedge clk_in) begin
      host_word_out <= host_pop_in ? DW'(host_seq_ff) : ~host_word_out;
      for (int c = 0; c < 2; c++)
         chan_word_out[c] <= chan_pop_in[c] ? DW'({c[0], chan_seq_ff[c]}) : ~chan_word_out[c];
   end
   always_comb
      for (int c = 0; c < 2; c++)
         chan_busy_out[c] = (busy_cnt_ff[c] != 3'h0);
endmodule : rs_far_model

// ### tb/test_rs_stripe_controller.sv
// Purpose: Self-checking bench of the stripe controller
// Assumes: Counts keep all FIFOs ready except in the paused write and read tests
// Notes:   Words carry a sequence number to check stripe order
module test_rs_stripe_controller import rs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic SYS_CLK_IN = 0, RST_N_IN = 0, CE_IN = 1, COMMAND_REQUEST_IN = 0;
   logic [2:0] COMMAND_CODE_IN = 3'h0;
   logic [AW-1:0] START_BLOCK_INDEX_IN = '0, TRANSFER_BLOCK_COUNT_IN = '0;
   logic [AW-1:0] CHAN0_CAPACITY_IN = 48'h0000_1234_5678, ARRAY_CAPACITY_OUT;
   logic ARRAY_BUSY_OUT, SECTOR_SIZE_MODE_OUT, ARRAY_ERROR_FLAG_OUT, CHAN0_SECTOR_MODE_IN = 1;
   logic [1:0][31:0] CHANNEL_ERROR_VECTOR_OUT, CHAN_ERROR_VECTOR_IN = '0;
   logic [CW-1:0] HOST_RX_FIFO_COUNT_IN = 16'h0, HOST_TX_FIFO_COUNT_IN = 16'h0100;
   logic HOST_RX_FIFO_PUSH_OUT, HOST_TX_FIFO_POP_OUT, HOST_TX_FIFO_EMPTY_UNUSED_IN = 0;
   logic [DW-1:0] HOST_RX_FIFO_WORD_OUT, HOST_TX_FIFO_WORD_IN, CHAN_TX_FIFO_WORD_OUT;
   logic [1:0] CHAN_REQUEST_OUT, CHAN_BUSY_IN, CHAN_TX_FIFO_PUSH_OUT, CHAN_RX_FIFO_POP_OUT;
   rs_cmd_t [1:0] CHAN_CMD_OUT;
   logic [1:0][CW-1:0] CHAN_TX_FIFO_FILL_IN = '0, CHAN_RX_FIFO_FILL_IN = {2{16'h0100}};
   logic [1:0][DW-1:0] CHAN_RX_FIFO_WORD_IN;
   int miscompares = 0, samples_checked = 0, cycles = 0;
   int n_hpop, n_tpush, n_rpush, first_ch, rd_first;
   int n_tp[2], n_rp[2];
   rs_stripe_controller i_rs_stripe_controller (.*);
   rs_far_model i_rs_far_model (.clk_in(SYS_CLK_IN), .rst_n_in(RST_N_IN),
      .host_pop_in(HOST_TX_FIFO_POP_OUT), .host_word_out(HOST_TX_FIFO_WORD_IN),
      .chan_req_in(CHAN_REQUEST_OUT), .chan_busy_out(CHAN_BUSY_IN),
      .chan_pop_in(CHAN_RX_FIFO_POP_OUT), .chan_word_out(CHAN_RX_FIFO_WORD_IN));
   always #5 SYS_CLK_IN = ~SYS_CLK_IN;
   task automatic check(input string nm, input logic [DW-1:0] exp, input logic [DW-1:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : check
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report
   task automatic run_cmd(input logic [2:0] code, input logic [AW-1:0] a, input logic [AW-1:0] n);
      int i;
      i = 0;
      {n_hpop, n_rpush, n_tp[0], n_tp[1], n_rp[0], n_rp[1]} = '0;
      @(posedge SYS_CLK_IN);
      #1;
      COMMAND_REQUEST_IN = 1;
      COMMAND_CODE_IN = code;
      START_BLOCK_INDEX_IN = a;
      TRANSFER_BLOCK_COUNT_IN = n;
      while (ARRAY_BUSY_OUT !== 1'b1 && i < 20) begin
         @(posedge SYS_CLK_IN);
         #1;
         i++;
      end
      COMMAND_REQUEST_IN = 0;
      check("busy raised", 1, ARRAY_BUSY_OUT);
      check("chan request", 2'b11, CHAN_REQUEST_OUT);
      while (ARRAY_BUSY_OUT === 1'b1 && i < 3000) begin
         @(posedge SYS_CLK_IN);
         #1;
         i++;
      end
      check("busy cleared", 0, ARRAY_BUSY_OUT);
      $display("command %0d done", code);
   endtask : run_cmd
   always @(posedge SYS_CLK_IN) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         final_report();
      end
   end
   always @(posedge SYS_CLK_IN) begin
      n_hpop += HOST_TX_FIFO_POP_OUT;
      for (int c = 0; c < 2; c++) begin
         n_rp[c] += CHAN_RX_FIFO_POP_OUT[c];
         if (CHAN_TX_FIFO_PUSH_OUT[c]) begin
            if (n_tpush == 0) first_ch = c;
            check("tx word", DW'(n_tpush), CHAN_TX_FIFO_WORD_OUT);
            n_tpush++;
            n_tp[c]++;
         end
      end
      if (HOST_RX_FIFO_PUSH_OUT) begin
         check("rx word", DW'({1'(rd_first ^ (n_rpush >> 3)), 16'(((n_rpush >> 4) << 3) + (n_rpush & 7))}),
               HOST_RX_FIFO_WORD_OUT);
         n_rpush++;
      end
   end
   initial begin
      repeat (4) @(posedge SYS_CLK_IN);
      #1 RST_N_IN = 1;
      check("capacity reset", 0, ARRAY_CAPACITY_OUT);
      check("mode reset", 0, SECTOR_SIZE_MODE_OUT);
      check("error reset", 0, ARRAY_ERROR_FLAG_OUT);
      run_cmd(CMD_IDENTIFY, '0, '0);
      check("capacity", 48'h0000_2468_acf0, ARRAY_CAPACITY_OUT);
      check("mode", 1, SECTOR_SIZE_MODE_OUT);
      run_cmd(CMD_SHUTDOWN, '0, '0);
      run_cmd(CMD_SMART, '0, '0);
      run_cmd(CMD_FLUSH, '0, '0);
      run_cmd(CMD_WRITE, 48'h1, 48'h3);
      check("host pops", 24, n_hpop);
      check("first channel", 1, first_ch);
      check("ch1 pushes", 16, n_tp[1]);
      check("ch0 pushes", 8, n_tp[0]);
      check("ch0 cmd", {CMD_WRITE, 48'h1, 48'h1}, CHAN_CMD_OUT[0]);
      check("ch1 cmd", {CMD_WRITE, 48'h0, 48'h2}, CHAN_CMD_OUT[1]);
      HOST_TX_FIFO_COUNT_IN = 16'h0000;
      fork
         run_cmd(CMD_WRITE, 48'h10, 48'h2);
         begin
            repeat (20) @(posedge SYS_CLK_IN);
            #1 check("write paused", 0, n_hpop);
            HOST_TX_FIFO_COUNT_IN = 16'h0008;
         end
      join
      check("slow host pops", 16, n_hpop);
      check("slow ch0 pushes", 8, n_tp[0]);
      check("slow ch1 pushes", 8, n_tp[1]);
      rd_first = 0;
      HOST_RX_FIFO_COUNT_IN = 16'h0200;
      fork
         run_cmd(CMD_READ, 48'h0, 48'h2);
         begin
            repeat (20) @(posedge SYS_CLK_IN);
            #1 check("read paused", 0, n_rp[0] + n_rp[1]);
            HOST_RX_FIFO_COUNT_IN = 16'h0000;
         end
      join
      check("ch0 pops", 8, n_rp[0]);
      check("ch1 pops", 8, n_rp[1]);
      check("rx pushes", 16, n_rpush);
      CHAN_ERROR_VECTOR_IN[1] = 32'h0000_0100;
      @(posedge SYS_CLK_IN);
      #1 check("vector set", {32'h0000_0100, 32'h0}, CHANNEL_ERROR_VECTOR_OUT);
      CHAN_ERROR_VECTOR_IN[1] = 32'h0;
      repeat (4) @(posedge SYS_CLK_IN);
      #1 check("error sticky", 1, ARRAY_ERROR_FLAG_OUT);
      check("vector copy", 0, CHANNEL_ERROR_VECTOR_OUT);
      final_report();
   end
endmodule : test_rs_stripe_controller
